// [hdl/pder_misr.sv]
// Purpose: signature register over the OTP bytes
// Assumes: one byte per valid strobe, addresses in ascending order
// Notes:   check result held until the next start
`default_nettype none
module pder_misr
  import pder_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       byte_valid,
  input  wire logic [4:0] byte_addr,
  input  wire logic [7:0] byte_data,
  input  wire logic [7:0] expected,
  output logic            done,
  output logic            fail
);
  logic [7:0] sig_reg;
  logic [7:0] sig_next;
  logic       done_reg;
  logic       fail_reg;
  wire  logic in_range;
  wire  logic last_byte;
  wire  logic [7:0] shifted;
  wire  logic [7:0] mixed;

  // Shift, fold in byte, reduce when the old top bit was set
  assign shifted   = {sig_reg[6:0], 1'b0};
  assign mixed     = shifted ^ byte_data;
  assign sig_next  = sig_reg[7] ? (mixed ^ PDER_MISR_POLY) : mixed; // RULE17
  assign in_range  = byte_valid && !done_reg &&
                     byte_addr >= PDER_OTP_FIRST; // RULE17
  assign last_byte = in_range && byte_addr == PDER_OTP_LAST;
  assign done      = done_reg;
  assign fail      = fail_reg;

  // Restart on start; verdict latched with the last byte
  always_ff @(posedge clk) begin
    if (!rst_n || start) begin
      sig_reg  <= PDER_MISR_RESET;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else if (in_range) begin
      sig_reg <= sig_next;
      if (last_byte) begin
        done_reg <= 1'b1;
        fail_reg <= sig_next != expected;
      end
    end
  end
endmodule // pder_misr
`default_nettype wire

// [hdl/pder_pkg.sv]
// Purpose: shared constants and types for the diagnostic error reporter
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes:   error codes, field positions and phase encodings live here
`default_nettype none
package pder_pkg;
  localparam logic [9:0] PDER_CODE_READY   = 10'h1E7;
  localparam logic [9:0] PDER_CODE_DEFECT  = 10'h1F4;
  localparam logic [9:0] PDER_CODE_OVERV   = 10'h1EA;
  localparam logic [9:0] PDER_CODE_FIELD   = 10'h1EB;
  localparam logic [9:0] PDER_CODE_UNDERV  = 10'h1EC;
  localparam logic [9:0] PDER_CODE_OFFSET  = 10'h1ED;
  // Detail bit positions in the 20-bit mode low field
  localparam int unsigned PDER_DET_ROT_BIT  = 0;
  localparam int unsigned PDER_DET_OTP_BIT  = 2;
  localparam int unsigned PDER_DET_HALL_BIT = 3;
  // Code field position in the 16-bit data word
  localparam int unsigned PDER_CODE_LSB_HI  = 6;
  // Signature register constants, frame counter and slot timer resets
  localparam logic [7:0] PDER_MISR_POLY     = 8'h1D;
  localparam logic [7:0] PDER_MISR_RESET    = 8'h00;
  localparam logic [4:0] PDER_OTP_FIRST     = 5'h01;
  localparam logic [4:0] PDER_OTP_LAST      = 5'h1F;
  localparam logic [2:0] PDER_FCNT_RESET    = 3'h0;
  localparam logic [15:0] PDER_SLOT_RESET   = 16'h0000;

  typedef enum logic [1:0] {
    PDER_PH_INIT1,
    PDER_PH_INIT2,
    PDER_PH_INIT3,
    PDER_PH_RUN
  } pder_phase_t;

  typedef enum logic [1:0] {
    PDER_FM_10,
    PDER_FM_16,
    PDER_FM_20
  } pder_fmode_t;

  // Diagnostic flags from the analog and digital sections
  typedef struct packed {
    logic watchdog_fail;
    logic core_uv;
    logic por_uv;
    logic rev_pol;
    logic offset_fail;
    logic field_range;
    logic supply_ov;
    logic supply_uv;
    logic rot_overflow;
    logic hall_break;
    logic channel_break;
  } pder_diag_t;

  // Frame content handed to the frame serializer
  typedef struct packed {
    logic [2:0]  count;
    logic        error;
    logic [15:0] data;
  } pder_frame_t;
endpackage : pder_pkg
`default_nettype wire

// [hdl/pder_top.sv]
// Purpose: PSI5 fault reporting: code selection, forced low, sync slot
// Assumes: flags synchronous to CLK; serializer outside consumes frames
// Notes:   one code per frame, chosen by a fixed priority
// Operation
// RULE1 - ECU starts each universal-bus period with a voltage sync pulse.
// RULE2 - After sync, wait configured shift, then start frame in own slot.
// RULE3 - Watchdog failure forces line drive low, no frames sent.
// RULE4 - Core supply undervoltage holds line drive low.
// RULE5 - Supply below power-on threshold holds line drive low.
// RULE6 - Run mode field out of range sends 0x1EB while flagged.
// RULE7 - Run mode supply overvoltage sends 0x1EA while flagged.
// RULE8 - Run mode supply undervoltage sends 0x1EC while flagged.
// RULE9 - Offset, field, supply and polarity faults recover when cleared.
// RULE10 - OTP checksum fail sends defect code from phase III until power off.
// RULE11 - Errors in phases I/II are masked, reported as defect in phase III.
// RULE12 - Run mode internal errors latch defect code until ECU reset.
// RULE13 - 20/16-bit modes: defect code in A15..A6, error bit set.
// RULE14 - Frame counter bits keep counting while errors are reported.
// RULE15 - 20-bit mode detail bits: A0 rotation, A2 OTP, A3 Hall.
// RULE16 - Hall break check can be removed by build option.
// RULE17 - OTP signature: shift left, XOR byte, XOR 29 if old MSB set.
// RULE18 - Supply and field faults not reported in phase III, only in run.
// RULE19 - 10/16-bit modes: codes in A9..A0, error bit set where present.
// RULE20 - Reverse polarity holds line drive low until corrected.
// RULE21 - Priority: forced low, then latched defect, then specific codes.
`default_nettype none
module pder_top
  import pder_pkg::*;
#(
  parameter bit HALL_CHECK_EN = 1'b1
)
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire pder_phase_t PHASE,
  input  wire pder_fmode_t FRAME_MODE,
  input  wire logic        SYNC_MODE,
  input  wire logic        SYNC_PULSE,
  input  wire logic        ASYNC_TICK,
  input  wire logic [15:0] SLOT_SHIFT,
  input  wire pder_diag_t  DIAG,
  input  wire logic [15:0] SENSOR_DATA,
  input  wire logic        OTP_START,
  input  wire logic        OTP_VALID,
  input  wire logic [4:0]  OTP_ADDR,
  input  wire logic [7:0]  OTP_DATA,
  input  wire logic [7:0]  OTP_SIGNATURE,
  input  wire logic        SER_BUSY,
  input  wire logic        SER_LINE,
  output logic             FRAME_START,
  output pder_frame_t      FRAME,
  output logic             LINE_CURRENT_DRIVE,
  output logic             DEFECT_LATCHED,
  output logic             OTP_CHECK_DONE,
  output logic             OTP_CHECK_FAIL
);
  logic              otp_done;
  logic              otp_fail;
  logic              defect_reg;
  logic              defect_next;
  logic [5:0]        detail_reg;
  logic [5:0]        detail_next;
  logic              masked_reg;
  logic              masked_next;
  logic [15:0]       wait_reg;
  logic [15:0]       wait_next;
  logic              waiting_reg;
  logic              waiting_next;
  logic [2:0]        fcnt_reg;
  logic [2:0]        fcnt_next;
  pder_frame_t       frame_reg;
  pder_frame_t       frame_next;
  logic              start_reg;
  wire  logic        force_low;
  wire  logic        run;
  wire  logic        hall_fault;
  wire  logic        internal_err;
  wire  logic        early_phase;
  wire  logic        trigger;
  wire  logic        slot_hit;
  wire  logic        send;
  wire  logic        have_code;
  wire  logic [9:0]  code;
  wire  logic [5:0]  detail_now;
  wire  logic [15:0] err_data;

  // Signature check over the OTP bytes
  pder_misr u_misr (
    .clk        (CLK),
    .rst_n      (RST_N),
    .start      (OTP_START),
    .byte_valid (OTP_VALID),
    .byte_addr  (OTP_ADDR),
    .byte_data  (OTP_DATA),
    .expected   (OTP_SIGNATURE),
    .done       (otp_done),
    .fail       (otp_fail)
  );

  // Fault classification; Hall check gated off by build option
  assign hall_fault   = HALL_CHECK_EN && DIAG.hall_break; // RULE16
  assign force_low    = DIAG.watchdog_fail || DIAG.core_uv ||
                        DIAG.por_uv || DIAG.rev_pol; // RULE3 RULE4 RULE5 RULE20
  assign run          = PHASE == PDER_PH_RUN;
  assign early_phase  = PHASE == PDER_PH_INIT1 || PHASE == PDER_PH_INIT2;
  assign internal_err = DIAG.rot_overflow || hall_fault ||
                        DIAG.channel_break || DIAG.watchdog_fail;
  assign detail_now   = {2'b00, hall_fault, otp_fail, 1'b0,
                         DIAG.rot_overflow}; // RULE15

  // Defect latch: OTP fail any time, run-mode internal errors
  assign defect_next  = defect_reg || otp_fail ||
                        (run && internal_err) ||
                        (PHASE == PDER_PH_INIT3 && masked_reg); // RULE10 RULE12
  assign detail_next  = detail_reg | ((otp_fail || run) ? detail_now : 6'h00);
  // Internal and offset errors during phases I/II only noted, shown in phase III
  assign masked_next  = masked_reg || (early_phase &&
                        (internal_err || DIAG.offset_fail)); // RULE11

  // Code choice by priority; supply/field codes only in run mode
  assign have_code = defect_reg ||
                     (run && (DIAG.offset_fail || DIAG.field_range ||
                      DIAG.supply_ov || DIAG.supply_uv)); // RULE18 RULE9
  assign code = defect_reg       ? PDER_CODE_DEFECT : // RULE21
                !run             ? PDER_CODE_READY  :
                DIAG.offset_fail ? PDER_CODE_OFFSET :
                DIAG.field_range ? PDER_CODE_FIELD  : // RULE6
                DIAG.supply_ov   ? PDER_CODE_OVERV  : // RULE7
                DIAG.supply_uv   ? PDER_CODE_UNDERV : // RULE8
                PDER_CODE_READY;

  // Code placement per frame width; 16-bit run codes sit low,
  // defect and phase III status sit high like the 20-bit layout
  assign err_data = (FRAME_MODE == PDER_FM_20) ?
                    {code, (defect_reg ? detail_reg : 6'h00)} : // RULE13
                    (FRAME_MODE == PDER_FM_16 && (defect_reg || !run)) ?
                    {code, 6'h00} : // RULE13
                    {6'h00, code}; // RULE19

  // Frame trigger: sync pulse plus slot delay, or free-running tick
  assign trigger  = SYNC_MODE ? SYNC_PULSE : ASYNC_TICK; // RULE1
  assign slot_hit = waiting_reg && wait_reg == 16'h0000;
  assign send     = slot_hit && !SER_BUSY && !force_low;
  assign waiting_next = (trigger && !force_low) ? 1'b1 :
                        send ? 1'b0 : waiting_reg;
  assign wait_next    = (trigger && !force_low) ?
                        (SYNC_MODE ? SLOT_SHIFT : 16'h0000) : // RULE2
                        (waiting_reg && wait_reg != 16'h0000) ?
                        wait_reg - 16'h0001 : wait_reg;
  assign fcnt_next    = send ? fcnt_reg + 3'h1 : fcnt_reg; // RULE14

  // Frame content; phase I/II frames keep status and count clear, ready frames keep status clear
  always_comb begin
    frame_next = frame_reg;
    if (send) begin
      if (run || PHASE == PDER_PH_INIT3) begin
        frame_next.count = fcnt_reg; // RULE14
        frame_next.error = have_code && FRAME_MODE != PDER_FM_10; // RULE13
        frame_next.data  = (have_code || !run) ? err_data : SENSOR_DATA;
      end else begin
        frame_next.count = PDER_FCNT_RESET;
        frame_next.error = 1'b0;
        frame_next.data  = SENSOR_DATA;
      end
    end
  end

  // Error state; defect holds until reset from the ECU
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      defect_reg <= 1'b0;
      detail_reg <= 6'h00;
      masked_reg <= 1'b0;
    end else begin
      defect_reg <= defect_next; // RULE12
      detail_reg <= detail_next;
      masked_reg <= masked_next;
    end
  end

  // Slot timing and frame registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wait_reg    <= PDER_SLOT_RESET;
      waiting_reg <= 1'b0;
      fcnt_reg    <= PDER_FCNT_RESET;
      frame_reg   <= '0;
      start_reg   <= 1'b0;
    end else begin
      wait_reg    <= wait_next;
      waiting_reg <= waiting_next;
      fcnt_reg    <= fcnt_next;
      frame_reg   <= frame_next;
      start_reg   <= send;
    end
  end

  // Forced faults override the serializer combinationally, no lag
  assign LINE_CURRENT_DRIVE = force_low ? 1'b0 : SER_LINE; // RULE3 RULE4
  assign FRAME_START    = start_reg && !force_low; // RULE5 RULE20
  assign FRAME          = frame_reg;
  assign DEFECT_LATCHED = defect_reg;
  assign OTP_CHECK_DONE = otp_done;
  assign OTP_CHECK_FAIL = otp_fail;
endmodule // pder_top
`default_nettype wire

// [tb/pder_assertions.sv]
// Purpose: port checks of the error reporter
// Assumes: bound to pder_top
// Notes:   frame fields judged when FRAME_START shows
`default_nettype none
module pder_assertions
  import pder_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire pder_phase_t PHASE,
  input wire pder_fmode_t FRAME_MODE,
  input wire pder_diag_t  DIAG,
  input wire pder_frame_t FRAME,
  input wire logic        FRAME_START,
  input wire logic        LINE_CURRENT_DRIVE,
  input wire logic        DEFECT_LATCHED,
  input wire logic        OTP_CHECK_FAIL
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Force faults beat whatever the serializer sends
  chk_wdog_low:
    assert property (DIAG.watchdog_fail |-> !LINE_CURRENT_DRIVE)
    else $error("line driven in watchdog fault");
  chk_core_low:
    assert property (DIAG.core_uv |-> !LINE_CURRENT_DRIVE)
    else $error("line driven in core undervoltage");
  chk_por_low:
    assert property (DIAG.por_uv |-> !LINE_CURRENT_DRIVE)
    else $error("line driven below power-on level");
  chk_revpol_low:
    assert property (DIAG.rev_pol |-> !LINE_CURRENT_DRIVE)
    else $error("line driven in reverse polarity");
  // Codes follow the inputs seen at the send edge
  chk_field_code:
    assert property (FRAME_START && $past(PHASE) == PDER_PH_RUN
      && $past(DIAG) == 11'h020 && $past(FRAME_MODE) == PDER_FM_20
      && !$past(DEFECT_LATCHED)
      |-> FRAME.data[15:6] == PDER_CODE_FIELD && FRAME.error)
    else $error("field code missing");
  chk_defect_code:
    assert property (FRAME_START && $past(DEFECT_LATCHED)
      && $past(PHASE) inside {PDER_PH_INIT3, PDER_PH_RUN}
      && $past(DIAG[10:7]) == 4'h0 && $past(FRAME_MODE) == PDER_FM_16
      |-> FRAME.data[15:6] == PDER_CODE_DEFECT && FRAME.error)
    else $error("defect code missing");
  chk_defect_hold:
    assert property (DEFECT_LATCHED |=> DEFECT_LATCHED)
    else $error("defect dropped without reset");
  chk_otp_defect:
    assert property (OTP_CHECK_FAIL && PHASE == PDER_PH_INIT3
      |-> ##[0:2] DEFECT_LATCHED)
    else $error("checksum fail not latched");
endmodule // pder_assertions
bind pder_top pder_assertions pder_assertions_i (
  .CLK(CLK), .RST_N(RST_N), .PHASE(PHASE), .FRAME_MODE(FRAME_MODE),
  .DIAG(DIAG), .FRAME(FRAME), .FRAME_START(FRAME_START),
  .LINE_CURRENT_DRIVE(LINE_CURRENT_DRIVE),
  .DEFECT_LATCHED(DEFECT_LATCHED), .OTP_CHECK_FAIL(OTP_CHECK_FAIL));
`default_nettype wire

// [tb/pder_ecu.sv]
// Purpose: ECU side: sync pulses and frame serializer
// Assumes: one frame keeps the wire busy BUSY_LEN cycles
// Notes:   idle line high, so a missing forced low shows
`default_nettype none
module pder_ecu #(
  parameter int BUSY_LEN = 6
)
(
  input  wire logic clk,
  input  wire logic req,
  input  wire logic frame_start,
  output logic      sync_pulse,
  output logic      ser_busy,
  output logic      ser_line
);
  timeunit 1ns;
  timeprecision 100ps;
  int left_n = 0;
  // Every period opens with a sync asked for by the bench
  assign sync_pulse = req;
  // Busy for a frame time; line toggles while sending
  always @(posedge clk) begin
    if (frame_start) left_n <= BUSY_LEN;
    else if (left_n > 0) left_n <= left_n - 1;
  end
  assign ser_busy = (left_n > 0);
  assign ser_line = ser_busy ? left_n[0] : 1'b1;
endmodule // pder_ecu
`default_nettype wire

// [tb/pder_top_tb.sv]
// Purpose: self-checking bench for the error reporter
// Assumes: one frame at a time, serializer idle at trigger
// Notes:   latency counted in edges from the trigger
`default_nettype none
module pder_top_tb import pder_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLK = 0, RST_N = 0, SYNC_MODE = 0, tick = 0, req = 0;
  pder_phase_t ph = PDER_PH_INIT1;
  pder_fmode_t fm = PDER_FM_20;
  pder_diag_t  dg = '0;
  logic [15:0] shift = 16'h0000, sdat = 16'hA5C3;
  logic        ostart = 0, oval = 0;
  logic [4:0]  oaddr = 5'h00;
  logic [7:0]  odat = 8'h00, osig = 8'h00;
  logic        fs, lcd, dl, odone, ofail, busy, sline, spulse;
  pder_frame_t fr;
  logic [2:0]  last_cnt = 3'h0;
  bit          have_cnt = 0;
  int          n_errors = 0, n_compared = 0;
  localparam logic [10:0] DTAB [4] = '{11'h040, 11'h020, 11'h010, 11'h008};
  localparam logic [9:0]  CTAB [4] = '{PDER_CODE_OFFSET, PDER_CODE_FIELD,
                                       PDER_CODE_OVERV, PDER_CODE_UNDERV};
  always #5 CLK = ~CLK;
  pder_top pder_top_i (.CLK(CLK), .RST_N(RST_N), .PHASE(ph),
    .FRAME_MODE(fm), .SYNC_MODE(SYNC_MODE), .SYNC_PULSE(spulse),
    .ASYNC_TICK(tick), .SLOT_SHIFT(shift), .DIAG(dg), .SENSOR_DATA(sdat),
    .OTP_START(ostart), .OTP_VALID(oval), .OTP_ADDR(oaddr), .OTP_DATA(odat),
    .OTP_SIGNATURE(osig), .SER_BUSY(busy), .SER_LINE(sline),
    .FRAME_START(fs), .FRAME(fr), .LINE_CURRENT_DRIVE(lcd),
    .DEFECT_LATCHED(dl), .OTP_CHECK_DONE(odone), .OTP_CHECK_FAIL(ofail));
  pder_ecu pder_ecu_i (.clk(CLK), .req(req), .frame_start(fs),
    .sync_pulse(spulse), .ser_busy(busy), .ser_line(sline));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic rst();
    RST_N = 0;
    repeat (3) @(posedge CLK);
    #1 RST_N = 1;
    have_cnt = 0;
  endtask
  // Trigger one frame; lat 0 means no frame may come
  task automatic send(input logic [15:0] d, input logic e, input int lat);
    int n = 0;
    logic [2:0] nxt;
    if (SYNC_MODE) req = 1;
    else tick = 1;
    do begin
      @(posedge CLK);
      #1 req = 0;
      tick = 0;
      n++;
    end while (fs !== 1'b1 && n < 40);
    if (lat == 0) chk(16'(fs), 16'h0000);
    else if (fs !== 1'b1) begin
      n_errors++;
      end_of_test();
    end else begin
      nxt = last_cnt + 3'h1;
      chk(16'(n), 16'(lat));
      chk(fr.data, d);
      chk(16'(fr.error), 16'(e));
      if (ph == PDER_PH_RUN && have_cnt) chk(16'(fr.count), 16'(nxt));
      last_cnt = fr.count;
      have_cnt = (ph == PDER_PH_RUN);
    end
    repeat (8) @(posedge CLK);
    #1;
  endtask
  // Feed bytes 1..31, signature worked out alongside
  task automatic otp(input logic bad);
    logic [7:0] m = 8'h00;
    ostart = 1;
    @(posedge CLK);
    #1 ostart = 0;
    for (int i = 1; i < 32; i++) begin
      oval = 1;
      oaddr = 5'(i);
      odat = 8'(i * 7 + 3);
      m = {m[6:0], 1'b0} ^ odat ^ (m[7] ? 8'h1D : 8'h00);
      osig = m ^ {7'h00, bad};
      @(posedge CLK);
      #1;
    end
    oval = 0;
    repeat (8) if (odone !== 1'b1) @(posedge CLK);
    #1 chk(16'(odone), 16'h0001);
    chk(16'(ofail), 16'(bad));
  endtask
  initial begin
    rst();
    otp(0);
    ph = PDER_PH_INIT3;
    dg.supply_ov = 1;
    send({PDER_CODE_READY, 6'h00}, 0, 2);
    ph = PDER_PH_RUN;
    SYNC_MODE = 1;
    shift = 16'h0005;
    dg = '0;
    send(sdat, 0, 7);
    // Recoverable codes in all three frame modes
    for (int k = 0; k < 4; k++) begin
      dg = pder_diag_t'(DTAB[k]);
      fm = pder_fmode_t'((k + 1) % 3);
      send(fm != PDER_FM_20 ? {6'h00, CTAB[k]} : {CTAB[k], 6'h00},
           fm != PDER_FM_10, 7);
      dg = '0;
      send(sdat, 0, 7);
    end
    // Recoverable forced lows; watchdog last, since it latches a defect
    for (int k = 7; k < 10; k++) begin
      dg = pder_diag_t'(11'h001 << k);
      #1 chk(16'(lcd), 16'h0000);
      send(16'h0000, 0, 0);
      dg = '0;
      send(sdat, 0, 7);
      chk(16'(lcd), 16'h0001);
    end
    fm = PDER_FM_20;
    dg = pder_diag_t'(11'h024);
    send({PDER_CODE_DEFECT, 6'h01}, 1, 7);
    dg = pder_diag_t'(11'h400);
    #1 chk(16'(lcd), 16'h0000);
    send(16'h0000, 0, 0);
    fm = PDER_FM_16;
    dg = '0;
    send({PDER_CODE_DEFECT, 6'h00}, 1, 7);
    chk(16'(dl), 16'h0001);
    $display("run mode test done");
    // Early error masked, then reported in phase three
    rst();
    ph = PDER_PH_INIT1;
    SYNC_MODE = 0;
    fm = PDER_FM_20;
    dg.channel_break = 1;
    send(sdat, 0, 2);
    dg = '0;
    ph = PDER_PH_INIT3;
    send({PDER_CODE_DEFECT, 6'h00}, 1, 2);
    $display("masking test done");
    rst();
    ph = PDER_PH_INIT1;
    otp(1);
    ph = PDER_PH_INIT3;
    send({PDER_CODE_DEFECT, 6'h04}, 1, 2);
    $display("checksum test done");
    end_of_test();
  end
endmodule // pder_top_tb
`default_nettype wire
